// ### src/afd_ancillary_inserter.sv
/*
 * Format-descriptor ancillary inserter: register file on a plain port, a stream
 * path that adds one ancillary packet after each control packet, and the
 * blanking window for ancillary placement on embedded-sync output.
 * Assumes a same-clock register master and stream neighbours with valid/ready.
 * Upstream must not offer beats while ce is low, since in_ready_ff then stands
 * frozen and a beat offered against it would be lost.
 */
// Contract
// - Inserted format code comes from register 3 bits [3:0].
// - Inserted aspect code comes from register 4 bit 0.
// - Four bar flags from register 5 bits [3:0] go into each packet.
// - First bar value from register 6 bits [15:0] goes into each packet.
// - Second bar value from register 7 bits [15:0] goes into each packet.
// - Ancillary placement on embedded-sync output only during vertical blanking.
// - Placement starts on the field's start line, stops when blanking ends.
// - Register 26 holds start line for first fields and progressive frames.
// - Register 27 holds start line for second interlaced fields.
// - Register 28 usable flag must be set before mode one is used.
// - Control bit 0 clear passes through; set adds packet after control packets.
// - Added packets carry identifier 0x41 and secondary identifier 0x5.
// - Ancillary packets in the stream carry packet type 0xD.
`timescale 1ns/1ps
`default_nettype none

module afd_ancillary_inserter
	import afd_ins_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rd_data_ff,
	input wire beat_s in_beat,
	input wire logic in_valid,
	output logic in_ready_ff,
	output beat_s out_beat_ff,
	output logic out_valid_ff,
	input wire logic out_ready,
	input wire logic embedded_sync,
	input wire logic vblank,
	input wire logic interlaced,
	input wire logic second_field,
	input wire logic [LINE_W-1:0] line_no,
	output logic anc_window_ff
);

	// ----------------------------------------------------------------
	// Register file.
	// ----------------------------------------------------------------
	// Software-visible state. Reserved and unmapped indices have no storage,
	// so a write to one of them changes nothing.
	logic insert_enable_ff;
	logic nxt_insert_enable;

	insert_values_s values_ff;
	insert_values_s nxt_values;

	logic [LINE_W-1:0] first_line_ff;
	logic [LINE_W-1:0] nxt_first_line;

	logic [LINE_W-1:0] second_line_ff;
	logic [LINE_W-1:0] nxt_second_line;

	logic usable_ff;
	logic nxt_usable;

	logic [DATA_W-1:0] nxt_rd_data;
	ins_state_e state_ff;

	// Decodes writes; narrow fields take the low bits of the write data.
	// A write lands at the edge that samples its strobe, so a read strobe in
	// the very next cycle already returns the new value.
	always_comb begin
		nxt_insert_enable = insert_enable_ff;
		nxt_values = values_ff;
		nxt_first_line = first_line_ff;
		nxt_second_line = second_line_ff;
		nxt_usable = usable_ff;
		if (reg_wr) begin
			case (reg_addr)
				REG_CONTROL: begin
					nxt_insert_enable = reg_wr_data[0];
				end
				REG_FORMAT_CODE: begin
					nxt_values.format_code = reg_wr_data[CODE_W-1:0];
				end
				REG_ASPECT_CODE: begin
					nxt_values.aspect_code = reg_wr_data[0];
				end
				REG_BAR_FLAGS: begin
					nxt_values.bar_flags = reg_wr_data[CODE_W-1:0];
				end
				REG_BAR_VALUE_ONE: begin
					nxt_values.bar_value_one = reg_wr_data[BAR_W-1:0];
				end
				REG_BAR_VALUE_TWO: begin
					nxt_values.bar_value_two = reg_wr_data[BAR_W-1:0];
				end
				REG_FIRST_FIELD_LINE: begin
					nxt_first_line = reg_wr_data[LINE_W-1:0];
				end
				REG_SECOND_FIELD_LINE: begin
					nxt_second_line = reg_wr_data[LINE_W-1:0];
				end
				REG_MODE_ONE_USABLE: begin
					nxt_usable = reg_wr_data[0];
				end
				// Status, reserved and unmapped indices keep every field as it was.
				default: begin
					nxt_usable = usable_ff;
				end
			endcase
		end
	end

	// Read data for the cycle after the strobe; unmapped indices read zero.
	// The word drops back to zero after one cycle, so a late sample sees zero.
	always_comb begin
		nxt_rd_data = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_CONTROL: begin
					nxt_rd_data[0] = insert_enable_ff;
				end
				REG_FORMAT_CODE: begin
					nxt_rd_data[CODE_W-1:0] = values_ff.format_code;
				end
				REG_ASPECT_CODE: begin
					nxt_rd_data[0] = values_ff.aspect_code;
				end
				REG_BAR_FLAGS: begin
					nxt_rd_data[CODE_W-1:0] = values_ff.bar_flags;
				end
				REG_BAR_VALUE_ONE: begin
					nxt_rd_data[BAR_W-1:0] = values_ff.bar_value_one;
				end
				REG_BAR_VALUE_TWO: begin
					nxt_rd_data[BAR_W-1:0] = values_ff.bar_value_two;
				end
				// Status is read-only; a write to its index is dropped.
				REG_STATUS: begin
					nxt_rd_data[0] = (state_ff == st_gen);
					nxt_rd_data[1] = anc_window_ff;
				end
				REG_FIRST_FIELD_LINE: begin
					nxt_rd_data[LINE_W-1:0] = first_line_ff;
				end
				REG_SECOND_FIELD_LINE: begin
					nxt_rd_data[LINE_W-1:0] = second_line_ff;
				end
				REG_MODE_ONE_USABLE: begin
					nxt_rd_data[0] = usable_ff;
				end
				default: begin
					nxt_rd_data = '0;
				end
			endcase
		end
	end

	// Registers the register file and the read data.
	// Low ce freezes every register here, the read data word included.
	// Reset clears every field, so software reloads the values after a reset.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			insert_enable_ff <= 1'b0;
			values_ff <= '{CODE_RESET, 1'b0, CODE_RESET, BAR_RESET, BAR_RESET};
			first_line_ff <= LINE_RESET;
			second_line_ff <= LINE_RESET;
			usable_ff <= 1'b0;
			reg_rd_data_ff <= '0;
		end else if (ce) begin
			insert_enable_ff <= nxt_insert_enable;
			values_ff <= nxt_values;
			first_line_ff <= nxt_first_line;
			second_line_ff <= nxt_second_line;
			usable_ff <= nxt_usable;
			reg_rd_data_ff <= nxt_rd_data;
		end
	end

	// ----------------------------------------------------------------
	// Ancillary packet content.
	// ----------------------------------------------------------------
	// The snapshot is the only copy of the values that the generator reads.
	// Taking it at the control packet's last beat lets software rewrite the
	// live registers while a packet is going out without tearing that packet.
	insert_values_s snap_ff;
	insert_values_s nxt_snap;

	logic [WORD_W-1:0] gen_word [ANC_BEATS];
	logic [7:0] first_udw;
	logic [7:0] flags_udw;

	// Builds the twelve beats of the added packet from the snapshot.
	// Byte words are ten bits wide with the two top bits held at zero.
	// The first user word holds the format code just above the aspect bit.
	// The two words after the first user word are reserved and sent as zero.
	always_comb begin
		first_udw = '0;
		first_udw[UDW_FORMAT_POS +: CODE_W] = snap_ff.format_code;
		first_udw[UDW_AR_POS] = snap_ff.aspect_code;
		flags_udw = '0;
		flags_udw[UDW_FLAGS_POS +: CODE_W] = snap_ff.bar_flags;
		gen_word[0] = {{(WORD_W-TYPE_W){1'b0}}, TYPE_ANCILLARY};
		gen_word[1] = {2'b00, ANC_DATA_IDENTIFIER};
		gen_word[2] = {2'b00, ANC_SECONDARY_IDENTIFIER};
		gen_word[3] = {2'b00, ANC_DATA_COUNT};
		gen_word[4] = {2'b00, first_udw};
		gen_word[5] = '0;
		gen_word[6] = '0;
		gen_word[7] = {2'b00, flags_udw};
		gen_word[8] = {2'b00, snap_ff.bar_value_one[BAR_W-1:8]};
		gen_word[9] = {2'b00, snap_ff.bar_value_one[7:0]};
		gen_word[10] = {2'b00, snap_ff.bar_value_two[BAR_W-1:8]};
		gen_word[11] = {2'b00, snap_ff.bar_value_two[7:0]};
	end

	// ----------------------------------------------------------------
	// Stream path.
	// ----------------------------------------------------------------
	// The output register is the only buffer. Input is refused while it is
	// full, which halves the peak rate but keeps in_ready_ff a plain
	// flip-flop with no combinational path back from out_ready.
	ins_state_e nxt_state;
	logic [IDX_W-1:0] idx_ff;
	logic [IDX_W-1:0] nxt_idx;

	logic in_ctrl_ff;
	logic nxt_in_ctrl;

	beat_s nxt_out_beat;
	logic nxt_out_valid;
	logic nxt_in_ready;

	logic accept;
	logic slot_free;
	logic beat_is_ctrl;

	// One output slot; input is taken only while the slot is known empty.
	// The packet type is read on the first beat and remembered for the rest.
	always_comb begin
		accept = in_valid && in_ready_ff;
		slot_free = !out_valid_ff || out_ready;
		beat_is_ctrl = in_beat.sop ? (in_beat.data[TYPE_W-1:0] == TYPE_CONTROL) : in_ctrl_ff;
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_in_ctrl = in_ctrl_ff;
		nxt_snap = snap_ff;
		nxt_out_beat = out_beat_ff;
		nxt_out_valid = out_valid_ff && !out_ready;
		case (state_ff)
			st_pass: begin
				if (accept) begin
					nxt_out_beat = in_beat;
					nxt_out_valid = 1'b1;
					nxt_in_ctrl = beat_is_ctrl;
					// The enable counts as it stands at the control packet's last beat.
					if (in_beat.eop && beat_is_ctrl && insert_enable_ff) begin
						nxt_state = st_gen;
						nxt_idx = '0;
						nxt_snap = values_ff;
					end
				end
			end
			st_gen: begin
				// Each word waits for a free slot, so downstream stalls are honoured.
				if (slot_free) begin
					nxt_out_beat.sop = (idx_ff == '0);
					nxt_out_beat.eop = (idx_ff == IDX_LAST);
					nxt_out_beat.data = gen_word[idx_ff];
					nxt_out_valid = 1'b1;
					if (idx_ff == IDX_LAST) begin
						nxt_state = st_pass;
					end else begin
						nxt_idx = idx_ff + 1'b1;
					end
				end
			end
			default: begin
				nxt_state = st_pass;
			end
		endcase
		// Ready follows the next slot state, so a taken beat is never overwritten.
		// This costs one idle cycle per beat but needs no skid buffer.
		nxt_in_ready = (nxt_state == st_pass) && !nxt_out_valid;
	end

	// Registers the stream path.
	// Ready is low in reset and rises at the first enabled edge after release.
	// The generator index restarts from zero at every added packet.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_ff <= st_pass;
			idx_ff <= '0;
			in_ctrl_ff <= 1'b0;
			snap_ff <= '{CODE_RESET, 1'b0, CODE_RESET, BAR_RESET, BAR_RESET};
			out_beat_ff <= '0;
			out_valid_ff <= 1'b0;
			in_ready_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			in_ctrl_ff <= nxt_in_ctrl;
			snap_ff <= nxt_snap;
			out_beat_ff <= nxt_out_beat;
			out_valid_ff <= nxt_out_valid;
			in_ready_ff <= nxt_in_ready;
		end
	end

	// ----------------------------------------------------------------
	// Blanking window for ancillary placement.
	// ----------------------------------------------------------------
	// The window is reported as a flag only and does not hold back the stream.
	// Mode one settings reach it only through the usable flag and start lines.
	// Timing levels come from same-clock output timing logic, so no
	// synchronisers sit in front of it.
	anc_line_window u_window (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.embedded_sync(embedded_sync),
		.vblank(vblank),
		.interlaced(interlaced),
		.second_field(second_field),
		.line_no(line_no),
		.first_field_anc_start_line(first_line_ff),
		.second_field_anc_start_line(second_line_ff),
		.video_mode_one_usable(usable_ff),
		.window_ff(anc_window_ff)
	);

endmodule // afd_ancillary_inserter

`default_nettype wire

// ### src/afd_ins_pkg.sv
/*
 * Shared constants and types for the format-descriptor ancillary inserter:
 * register indices, field layouts, reset values, packet codes and stream carriers.
 * Assumes it is compiled before every module that imports it.
 */
package afd_ins_pkg;

	// ----------------------------------------------------------------
	// Register indices on the plain register port.
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_CONTROL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_FORMAT_CODE = 5'h03;
	localparam logic [ADDR_W-1:0] REG_ASPECT_CODE = 5'h04;
	localparam logic [ADDR_W-1:0] REG_BAR_FLAGS = 5'h05;
	localparam logic [ADDR_W-1:0] REG_BAR_VALUE_ONE = 5'h06;
	localparam logic [ADDR_W-1:0] REG_BAR_VALUE_TWO = 5'h07;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] REG_FIRST_FIELD_LINE = 5'h1A;
	localparam logic [ADDR_W-1:0] REG_SECOND_FIELD_LINE = 5'h1B;
	localparam logic [ADDR_W-1:0] REG_MODE_ONE_USABLE = 5'h1C;

	// ----------------------------------------------------------------
	// Field widths and reset values.
	// ----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int CODE_W = 4;
	localparam int BAR_W = 16;
	localparam int LINE_W = 16;
	localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;
	localparam logic [BAR_W-1:0] BAR_RESET = 16'h0000;
	localparam logic [LINE_W-1:0] LINE_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Stream packet codes and ancillary layout.
	// ----------------------------------------------------------------
	localparam int TYPE_W = 4;
	localparam logic [TYPE_W-1:0] TYPE_CONTROL = 4'hF;
	localparam logic [TYPE_W-1:0] TYPE_ANCILLARY = 4'hD;
	localparam int WORD_W = 10;
	localparam logic [7:0] ANC_DATA_IDENTIFIER = 8'h41;
	localparam logic [7:0] ANC_SECONDARY_IDENTIFIER = 8'h05;
	localparam logic [7:0] ANC_DATA_COUNT = 8'h08;
	localparam int ANC_BEATS = 12;
	localparam int IDX_W = 4;
	localparam logic [IDX_W-1:0] IDX_LAST = 4'hB;
	// Bit positions inside the first user word and the bar flags word.
	localparam int UDW_AR_POS = 2;
	localparam int UDW_FORMAT_POS = 3;
	localparam int UDW_FLAGS_POS = 4;

	// ----------------------------------------------------------------
	// Carriers.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sop;
		logic eop;
		logic [WORD_W-1:0] data;
	} beat_s;

	typedef struct packed {
		logic [CODE_W-1:0] format_code;
		logic aspect_code;
		logic [CODE_W-1:0] bar_flags;
		logic [BAR_W-1:0] bar_value_one;
		logic [BAR_W-1:0] bar_value_two;
	} insert_values_s;

	typedef enum logic {
		st_pass,
		st_gen
	} ins_state_e;

endpackage

// ### src/anc_line_window.sv
/*
 * Vertical-blanking window in which queued ancillary packets may be placed
 * on embedded-sync output, opened on the per-field start line.
 * Assumes timing inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module anc_line_window
	import afd_ins_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic embedded_sync,
	input wire logic vblank,
	input wire logic interlaced,
	input wire logic second_field,
	input wire logic [LINE_W-1:0] line_no,
	input wire logic [LINE_W-1:0] first_field_anc_start_line,
	input wire logic [LINE_W-1:0] second_field_anc_start_line,
	input wire logic video_mode_one_usable,
	output logic window_ff
);

	// ----------------------------------------------------------------
	// Window control.
	// ----------------------------------------------------------------
	logic nxt_window;
	logic [LINE_W-1:0] start_line;
	logic allowed;

	// Opens on the start line of the current field and closes with blanking.
	always_comb begin
		start_line = (interlaced && second_field) ? second_field_anc_start_line
			: first_field_anc_start_line;
		allowed = video_mode_one_usable && embedded_sync && vblank;
		nxt_window = window_ff;
		if (!allowed) begin
			nxt_window = 1'b0;
		end else if (line_no == start_line) begin
			nxt_window = 1'b1;
		end
	end

	// Registers the window.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			window_ff <= 1'b0;
		end else if (ce) begin
			window_ff <= nxt_window;
		end
	end

endmodule // anc_line_window

`default_nettype wire

// ### tb/afd_ancillary_inserter_asserts.sv
/*
 * Port-level checker for the inserter, bound to its top module.
 * Assumes ce stays high while checking and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module afd_ancillary_inserter_asserts
	import afd_ins_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rd_data_ff,
	input wire beat_s in_beat,
	input wire logic in_valid,
	input wire logic in_ready_ff,
	input wire beat_s out_beat_ff,
	input wire logic out_valid_ff,
	input wire logic out_ready,
	input wire logic embedded_sync,
	input wire logic vblank,
	input wire logic interlaced,
	input wire logic [LINE_W-1:0] line_no,
	input wire logic anc_window_ff
);
	// ----------------------------------------------------------------
	// Shadow state.
	// ----------------------------------------------------------------
	logic en_sh, use_sh, asp_sh, in_ctrl, pend, exp, asnap, ctrl_now;
	logic [3:0] fmt_sh, fsnap, idx;
	logic [15:0] b1_sh, bsnap, ln1_sh;

	assign ctrl_now = in_beat.sop ? (in_beat.data[3:0] == TYPE_CONTROL) : in_ctrl;

	// Mirrors register writes and tracks when an added packet is due.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			{en_sh, use_sh, asp_sh, in_ctrl, pend, exp, asnap} <= '0;
			{fmt_sh, fsnap, idx, b1_sh, bsnap, ln1_sh} <= '0;
		end else if (ce) begin
			if (reg_wr && reg_addr == REG_CONTROL) en_sh <= reg_wr_data[0];
			if (reg_wr && reg_addr == REG_FORMAT_CODE) fmt_sh <= reg_wr_data[3:0];
			if (reg_wr && reg_addr == REG_ASPECT_CODE) asp_sh <= reg_wr_data[0];
			if (reg_wr && reg_addr == REG_BAR_VALUE_ONE) b1_sh <= reg_wr_data[15:0];
			if (reg_wr && reg_addr == REG_FIRST_FIELD_LINE) ln1_sh <= reg_wr_data[15:0];
			if (reg_wr && reg_addr == REG_MODE_ONE_USABLE) use_sh <= reg_wr_data[0];
			if (in_valid && in_ready_ff) begin
				if (in_beat.sop) in_ctrl <= in_beat.data[3:0] == TYPE_CONTROL;
				if (in_beat.eop && ctrl_now && en_sh) begin
					pend <= 1'b1;
					fsnap <= fmt_sh;
					asnap <= asp_sh;
					bsnap <= b1_sh;
				end
			end
			if (out_valid_ff && out_ready) begin
				if (exp) begin
					idx <= (idx == IDX_LAST) ? 4'h0 : idx + 4'h1;
					exp <= idx != IDX_LAST;
				end else if (pend && out_beat_ff.eop) begin
					exp <= 1'b1;
					pend <= 1'b0;
				end
			end
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n || !ce);

	// ----------------------------------------------------------------
	// Properties.
	// ----------------------------------------------------------------
	property p_rd_idle;
		!reg_rd |=> reg_rd_data_ff == 32'h0;
	endproperty
	property p_pass;
		in_valid && in_ready_ff |=> out_valid_ff && out_beat_ff == $past(in_beat);
	endproperty
	property p_gen_block;
		in_valid && in_ready_ff && in_beat.eop && ctrl_now && en_sh |=> !in_ready_ff [*8];
	endproperty
	property p_head;
		exp && idx == 4'h0 && out_valid_ff |-> out_beat_ff.sop && out_beat_ff.data == {6'h00, TYPE_ANCILLARY};
	endproperty
	property p_ids;
		exp && out_valid_ff && (idx == 4'h1 || idx == 4'h2) |-> out_beat_ff.data == (idx == 4'h1 ? 10'h041 : 10'h005);
	endproperty
	property p_udw;
		exp && out_valid_ff && idx == 4'h4 |-> out_beat_ff.data == {3'h0, fsnap, asnap, 2'h0};
	endproperty
	property p_bar;
		exp && out_valid_ff && idx == 4'h8 |-> out_beat_ff.data == {2'h0, bsnap[15:8]};
	endproperty
	property p_win_off;
		!vblank || !embedded_sync |=> !anc_window_ff;
	endproperty
	property p_win_on;
		embedded_sync && vblank && !interlaced && use_sh && line_no == ln1_sh |=> anc_window_ff;
	endproperty

	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero after idle cycle");
	a_pass: assert property (p_pass) else $error("taken beat not forwarded next cycle");
	a_gen_block: assert property (p_gen_block) else $error("input open during packet generation");
	a_head: assert property (p_head) else $error("added packet header wrong");
	a_ids: assert property (p_ids) else $error("added packet identifiers wrong");
	a_udw: assert property (p_udw) else $error("format or aspect word wrong");
	a_bar: assert property (p_bar) else $error("bar value word wrong");
	a_win_off: assert property (p_win_off) else $error("window open outside blanking");
	a_win_on: assert property (p_win_on) else $error("window not opened on start line");

	c_added: cover property (exp && idx == IDX_LAST && out_valid_ff && out_ready);
	c_window: cover property (anc_window_ff);
	c_stall: cover property (out_valid_ff && !out_ready);
endmodule // afd_ancillary_inserter_asserts

bind afd_ancillary_inserter afd_ancillary_inserter_asserts i_asserts (.ref_clk, .rst_n, .ce, .reg_addr,
	.reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data_ff, .in_beat, .in_valid, .in_ready_ff, .out_beat_ff,
	.out_valid_ff, .out_ready, .embedded_sync, .vblank, .interlaced, .line_no, .anc_window_ff);
`default_nettype wire

// ### tb/afd_ancillary_inserter_tb.sv
/*
 * Self-checking bench for the inserter: register table, stream, window.
 * Assumes the sink model and bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module afd_ancillary_inserter_tb
	import afd_ins_pkg::*;
;
	typedef struct {logic [4:0] a; logic [31:0] r;} row_s;
	logic ref_clk, rst_n, ce, reg_wr, reg_rd, in_valid, out_ready, slow, embedded_sync, vblank;
	logic interlaced, second_field, in_ready_ff, out_valid_ff, anc_window_ff;
	logic [4:0] reg_addr;
	logic [31:0] reg_wr_data, reg_rd_data_ff, v;
	logic [15:0] line_no;
	beat_s in_beat, out_beat_ff;
	beat_s exp_q[$];
	int fails, n_compared;
	row_s rows[13] = '{'{5'h00, 32'h1}, '{5'h03, 32'hF}, '{5'h04, 32'h1}, '{5'h05, 32'hF},
		'{5'h06, 32'hFFFF}, '{5'h07, 32'hFFFF}, '{5'h01, 32'h0}, '{5'h02, 32'h0}, '{5'h08, 32'h0},
		'{5'h1A, 32'hFFFF}, '{5'h1B, 32'hFFFF}, '{5'h1C, 32'h1}, '{5'h1F, 32'h0}};

	afd_ancillary_inserter i_afd_ancillary_inserter (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rd_data_ff(reg_rd_data_ff), .in_beat(in_beat), .in_valid(in_valid), .in_ready_ff(in_ready_ff),
		.out_beat_ff(out_beat_ff), .out_valid_ff(out_valid_ff), .out_ready(out_ready),
		.embedded_sync(embedded_sync), .vblank(vblank), .interlaced(interlaced),
		.second_field(second_field), .line_no(line_no), .anc_window_ff(anc_window_ff));
	afd_sink_model i_sink (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .beat(out_beat_ff),
		.valid(out_valid_ff), .ready(out_ready));

	// ----------------------------------------------------------------
	// Tasks.
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample mid-cycle.
	task automatic rd(input logic [4:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		v = reg_rd_data_ff;
		@(posedge ref_clk);
	endtask
	// Holds the beat until ready is high at a rising edge.
	task automatic send(input logic s, input logic e, input logic [9:0] d);
		logic rdy;
		in_beat <= '{s, e, d};
		in_valid <= 1'b1;
		exp_q.push_back('{s, e, d});
		do begin
			@(negedge ref_clk) rdy = in_ready_ff;
			@(posedge ref_clk);
		end while (rdy !== 1'b1);
	endtask
	task automatic push_anc(input logic [3:0] f, input logic a, input logic [3:0] fl, input logic [15:0] b1,
		input logic [15:0] b2);
		logic [9:0] w[12];
		w = '{10'h00D, 10'h041, 10'h005, 10'h008, {3'h0, f, a, 2'h0}, 10'h000, 10'h000, {2'h0, fl, 4'h0},
			{2'h0, b1[15:8]}, {2'h0, b1[7:0]}, {2'h0, b2[15:8]}, {2'h0, b2[7:0]}};
		foreach (w[i]) exp_q.push_back('{i == 0, i == 11, w[i]});
	endtask
	task automatic cmp_stream(input string name);
		in_valid <= 1'b0;
		repeat (300) if (i_sink.got.size() < exp_q.size()) @(posedge ref_clk);
		check(i_sink.got.size(), exp_q.size());
		foreach (exp_q[i]) check(i_sink.got[i], exp_q[i]);
		exp_q.delete();
		i_sink.got.delete();
		$display("done: %s", name);
	endtask
	task automatic win(input logic [15:0] l, input logic vb, input logic il, input logic e);
		vblank <= vb;
		interlaced <= il;
		second_field <= il;
		line_no <= l;
		@(posedge ref_clk);
		@(negedge ref_clk);
		check(anc_window_ff, e);
		@(posedge ref_clk);
	endtask
	task automatic complete_run();
		$display("compared=%0d fails=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Clock of 25 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Watchdog against a hung handshake.
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, in_valid, slow, embedded_sync, vblank, interlaced, second_field} = '0;
		ce = 1'b1;
		reg_addr = '0;
		reg_wr_data = '0;
		in_beat = '0;
		line_no = '0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		check(out_valid_ff, 1'b0);
		check(in_ready_ff, 1'b1);
		@(posedge ref_clk);
		$display("done: reset release");
		// Each row: reset value, then all-ones written and the kept field read back.
		foreach (rows[i]) begin
			rd(rows[i].a);
			check(v, 32'h0);
			wr(rows[i].a, 32'hFFFFFFFF);
			rd(rows[i].a);
			check(v, rows[i].r);
		end
		$display("done: registers");
		wr(5'h1C, 32'h0);
		wr(5'h00, 32'h0);
		send(1'b1, 1'b1, 10'h00F);
		send(1'b1, 1'b0, 10'h000);
		send(1'b0, 1'b1, 10'h155);
		cmp_stream("pass-through");
		slow <= 1'b1;
		wr(5'h03, 32'h9);
		wr(5'h04, 32'h1); // 16:9 content
		wr(5'h05, 32'hA);
		wr(5'h06, 32'h1234);
		wr(5'h07, 32'hBEEF);
		wr(5'h00, 32'h1);
		send(1'b1, 1'b0, 10'h00F);
		send(1'b0, 1'b1, 10'h3FF);
		push_anc(4'h9, 1'b1, 4'hA, 16'h1234, 16'hBEEF);
		in_valid <= 1'b0;
		wr(5'h03, 32'h8);
		send(1'b1, 1'b0, 10'h00D);
		send(1'b0, 1'b1, 10'h2AA);
		send(1'b1, 1'b1, 10'h00F);
		push_anc(4'h8, 1'b1, 4'hA, 16'h1234, 16'hBEEF);
		cmp_stream("insertion with stalls");
		wr(5'h1A, 32'h5);
		wr(5'h1B, 32'h9);
		wr(5'h1C, 32'h1);
		embedded_sync <= 1'b1;
		win(16'h4, 1'b1, 1'b0, 1'b0);
		win(16'h5, 1'b1, 1'b0, 1'b1);
		win(16'h6, 1'b1, 1'b0, 1'b1);
		win(16'h7, 1'b0, 1'b0, 1'b0);
		win(16'h5, 1'b1, 1'b1, 1'b0);
		win(16'h9, 1'b1, 1'b1, 1'b1);
		rd(5'h08);
		check(v, 32'h2);
		wr(5'h1C, 32'h0);
		@(posedge ref_clk);
		@(negedge ref_clk);
		check(anc_window_ff, 1'b0);
		@(posedge ref_clk);
		$display("done: window");
		// Low ce must freeze the register file, so a write while it is low is lost.
		ce <= 1'b0;
		wr(5'h03, 32'h5);
		ce <= 1'b1;
		rd(5'h03);
		check(v, 32'h8);
		// A reset in mid-run clears the values and reopens the input.
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(5'h03);
		check(v, 32'h0);
		check(in_ready_ff, 1'b1);
		$display("done: clock enable and mid-run reset");
		complete_run();
	end
endmodule // afd_ancillary_inserter_tb
`default_nettype wire

// ### tb/afd_sink_model.sv
/*
 * Downstream sink model: accepts output beats, promptly or with stalls.
 * Assumes the inserter's output stream on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module afd_sink_model
	import afd_ins_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire beat_s beat,
	input wire logic valid,
	output var logic ready
);
	// ----------------------------------------------------------------
	// Acceptance.
	// ----------------------------------------------------------------
	beat_s got[$];

	// Records each accepted beat; when slow, ready drops every other cycle.
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ready <= 1'b0;
		end else begin
			if (valid && ready) got.push_back(beat);
			ready <= slow ? !ready : 1'b1;
		end
	end
endmodule // afd_sink_model
`default_nettype wire
